/* hw/tmerr_cfg.svh */
// Register offsets, field positions, reset values and encodings of the timer channel.
// Assumes a 32-bit AHB-Lite register bus decoded on the low address byte.
`ifndef TMERR_CFG_SVH
`define TMERR_CFG_SVH

// Register byte offsets
`define TMERR_OFS_MODE 8'h00
`define TMERR_OFS_IOC 8'h04
`define TMERR_OFS_START 8'h08
`define TMERR_OFS_FUNC 8'h0C
`define TMERR_OFS_PORT 8'h10
`define TMERR_OFS_CMPA 8'h14
`define TMERR_OFS_CMPB 8'h18
`define TMERR_OFS_COUNT 8'h1C
`define TMERR_OFS_STAT 8'h20

// Field positions
`define TMERR_MODE_LSB 0
`define TMERR_MODE_MSB 1
`define TMERR_PSC_LSB 2
`define TMERR_PSC_MSB 3
`define TMERR_IOC_LSB 0
`define TMERR_IOC_MSB 3
`define TMERR_START_BIT 0
`define TMERR_FUNC_A_LSB 0
`define TMERR_FUNC_A_MSB 1
`define TMERR_FUNC_B_LSB 2
`define TMERR_FUNC_B_MSB 3
`define TMERR_PORT_A_BIT 0
`define TMERR_PORT_B_BIT 1
`define TMERR_STAT_LSB 0
`define TMERR_STAT_MSB 2

// Pin function codes
`define TMERR_FUNC_HIZ 2'h0
`define TMERR_FUNC_PORT 2'h1
`define TMERR_FUNC_TIMER 2'h2

// Prescaler select codes and divide ratios minus one
`define TMERR_PSC_DIV1 2'h0
`define TMERR_PSC_DIV4 2'h1
`define TMERR_PSC_DIV16 2'h2
`define TMERR_PSC_M4 6'h03
`define TMERR_PSC_M16 6'h0F
`define TMERR_PSC_M64 6'h3F

// Reset values
`define TMERR_RST_CMP 16'hFFFF
`define TMERR_RST_COUNT 16'h0000
`define TMERR_RST_FUNC 2'h0

// Bus constants
`define TMERR_HTRANS_NONSEQ_BIT 1
`define TMERR_HRESP_OKAY 1'h0
`define TMERR_HADDR_MSB 7

`endif

/* hw/tmerr_pkg.sv */
// Types shared by the timer channel modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tmerr_pkg;

	typedef enum logic [1:0] {
		TMERR_NORMAL,
		TMERR_PWM1,
		TMERR_PWM_MODE_TWO,
		TMERR_PHASE
	} tmerr_mode_t;

	// Initial level and level on compare match for each side
	typedef struct packed {
		logic b_match;
		logic b_init;
		logic a_match;
		logic a_init;
	} tmerr_ioc_t;

	typedef struct packed {
		logic [1:0] func;
		logic port_level;
		logic timer_level;
	} tmerr_pinsel_t;

	typedef struct packed {
		logic level;
		logic oe;
	} tmerr_pin_t;

endpackage

/* hw/tmerr_cmp.sv */
// Compare unit: flags a match of counter and compare value on a count step.
// Assumes counter and compare value are in the same clock domain.
`timescale 1ns/1ps
module tmerr_cmp #(
	parameter int W = 16
) (
	// Operands
	input wire logic [W-1:0] count_i,
	input wire logic [W-1:0] compare_i,
	input wire logic step_i,
	// Result
	output logic match_o
);

	assign match_o = step_i && (count_i == compare_i);

endmodule // tmerr_cmp

/* hw/tmerr_pin.sv */
// Pin function selector: routes timer state or port value to one output pin.
// Assumes the pad outside resolves level and output enable.
`timescale 1ns/1ps
`include "tmerr_cfg.svh"
module tmerr_pin
	import tmerr_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Selection
	input wire tmerr_pinsel_t sel_i,
	// Pad
	output tmerr_pin_t pin_o
);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pin_o <= '0;
		end else begin
			case (sel_i.func)
				`TMERR_FUNC_TIMER: begin
					pin_o <= '{level: sel_i.timer_level, oe: 1'b1};
				end
				`TMERR_FUNC_PORT: begin
					// Port value goes straight out, timer state untouched
					pin_o <= '{level: sel_i.port_level, oe: 1'b1};
				end
				default: begin
					pin_o <= '0;
				end
			endcase
		end
	end

endmodule // tmerr_pin

/* hw/tmerr_top.sv */
// Timer channel with two compare outputs, output recovery support and AHB-Lite registers.
// Assumes a single AHB-Lite master, word transfers only, and synchronous phase inputs.
//
// Notes on behaviour
// - After reset timer outputs are low and pins stay high-impedance.
// - PWM mode two pin initialisation leaves the cycle-register output A alone.
// - PWM mode one pin initialisation sets output A only; B keeps its level.
// - I/O control selects both the initial level and the level on match.
// - In normal and phase modes each compare match drives its own output to its match level; PWM mode one drives only A, PWM mode two only B.
// - Counter runs while start is 1; when 0 it halts and changes only on a bus write of count.
`timescale 1ns/1ps
`include "tmerr_cfg.svh"
module tmerr_top
	import tmerr_pkg::*;
#(
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Phase counting inputs
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	// Channel output pins
	output logic channel_output_a_o,
	output logic channel_output_a_oe_o,
	output logic channel_output_b_o,
	output logic channel_output_b_oe_o
);

	// Bus state
	logic wr_q;
	logic [`TMERR_HADDR_MSB:0] waddr_q;
	logic take;
	logic wr_mode;
	logic wr_ioc;
	logic wr_start;
	logic wr_func;
	logic wr_port;
	logic wr_cmpa;
	logic wr_cmpb;
	logic wr_count;

	// Registers
	tmerr_mode_t mode_q;
	logic [1:0] psc_q;
	tmerr_ioc_t ioc_q;
	tmerr_ioc_t ioc_new;
	logic start_q;
	logic [1:0] func_a_q;
	logic [1:0] func_b_q;
	logic port_a_q;
	logic port_b_q;
	logic [CW-1:0] cmpa_q;
	logic [CW-1:0] cmpb_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;

	// Timer internal outputs
	logic out_a_q;
	logic out_b_q;

	// Counting
	logic [5:0] div_q;
	logic [5:0] div_max;
	logic div_tick;
	logic phase_a_q;
	logic phase_b_q;
	logic phase_step;
	logic phase_up;
	logic step;
	logic match_a;
	logic match_b;
	logic cycle_clear;
	logic [31:0] rdata;

	tmerr_pin_t pin_a;
	tmerr_pin_t pin_b;

	assign take = hsel_i && hready_i && htrans_i[`TMERR_HTRANS_NONSEQ_BIT];
	assign ioc_new = tmerr_ioc_t'(hwdata_i[`TMERR_IOC_MSB:`TMERR_IOC_LSB]);

	// Address phase capture; writes land in the following data phase
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wr_q <= 1'b0;
			waddr_q <= '0;
		end else if (hready_i) begin
			wr_q <= take && hwrite_i;
			waddr_q <= haddr_i[`TMERR_HADDR_MSB:0];
		end
	end

	assign wr_mode = wr_q && (waddr_q == `TMERR_OFS_MODE);
	assign wr_ioc = wr_q && (waddr_q == `TMERR_OFS_IOC);
	assign wr_start = wr_q && (waddr_q == `TMERR_OFS_START);
	assign wr_func = wr_q && (waddr_q == `TMERR_OFS_FUNC);
	assign wr_port = wr_q && (waddr_q == `TMERR_OFS_PORT);
	assign wr_cmpa = wr_q && (waddr_q == `TMERR_OFS_CMPA);
	assign wr_cmpb = wr_q && (waddr_q == `TMERR_OFS_CMPB);
	assign wr_count = wr_q && (waddr_q == `TMERR_OFS_COUNT);

	// Mode and prescaler
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mode_q <= TMERR_NORMAL;
			psc_q <= `TMERR_PSC_DIV1;
		end else if (wr_mode) begin
			mode_q <= tmerr_mode_t'(hwdata_i[`TMERR_MODE_MSB:`TMERR_MODE_LSB]);
			psc_q <= hwdata_i[`TMERR_PSC_MSB:`TMERR_PSC_LSB];
		end
	end

	// I/O control levels
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ioc_q <= '0;
		end else if (wr_ioc) begin
			ioc_q <= ioc_new;
		end
	end

	// Start bit
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			start_q <= 1'b0;
		end else if (wr_start) begin
			start_q <= hwdata_i[`TMERR_START_BIT];
		end
	end

	// Pin function and port levels
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			func_a_q <= `TMERR_RST_FUNC;
			func_b_q <= `TMERR_RST_FUNC;
			port_a_q <= 1'b0;
			port_b_q <= 1'b0;
		end else begin
			if (wr_func) begin
				func_a_q <= hwdata_i[`TMERR_FUNC_A_MSB:`TMERR_FUNC_A_LSB];
				func_b_q <= hwdata_i[`TMERR_FUNC_B_MSB:`TMERR_FUNC_B_LSB];
			end
			if (wr_port) begin
				port_a_q <= hwdata_i[`TMERR_PORT_A_BIT];
				port_b_q <= hwdata_i[`TMERR_PORT_B_BIT];
			end
		end
	end

	// Compare values
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cmpa_q <= `TMERR_RST_CMP;
			cmpb_q <= `TMERR_RST_CMP;
		end else begin
			if (wr_cmpa) begin
				cmpa_q <= hwdata_i[CW-1:0];
			end
			if (wr_cmpb) begin
				cmpb_q <= hwdata_i[CW-1:0];
			end
		end
	end

	// Prescaler: one-cycle count enable in the internal clocking modes
	always_comb begin
		case (psc_q)
			`TMERR_PSC_DIV1: div_max = '0;
			`TMERR_PSC_DIV4: div_max = `TMERR_PSC_M4;
			`TMERR_PSC_DIV16: div_max = `TMERR_PSC_M16;
			default: div_max = `TMERR_PSC_M64;
		endcase
	end

	assign div_tick = (div_q >= div_max);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			div_q <= '0;
		end else if (!start_q || div_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 6'h01;
		end
	end

	// Phase input history for quadrature decoding
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			phase_a_q <= 1'b0;
			phase_b_q <= 1'b0;
		end else begin
			phase_a_q <= phase_a_i;
			phase_b_q <= phase_b_i;
		end
	end

	assign phase_step = (phase_a_i != phase_a_q) || (phase_b_i != phase_b_q);
	assign phase_up = phase_a_i ^ phase_b_q;
	assign step = start_q && ((mode_q == TMERR_PHASE) ? phase_step : div_tick);

	tmerr_cmp #(
		.W(CW)
	) u_cmp_a (
		.count_i(count_q),
		.compare_i(cmpa_q),
		.step_i(step),
		.match_o(match_a)
	);

	tmerr_cmp #(
		.W(CW)
	) u_cmp_b (
		.count_i(count_q),
		.compare_i(cmpb_q),
		.step_i(step),
		.match_o(match_b)
	);

	// In both PWM modes compare A sets the cycle
	assign cycle_clear = match_a && ((mode_q == TMERR_PWM1) || (mode_q == TMERR_PWM_MODE_TWO));

	always_comb begin
		count_d = count_q;
		if (wr_count) begin
			count_d = hwdata_i[CW-1:0];
		end else if (step) begin
			if (mode_q == TMERR_PHASE) begin
				count_d = phase_up ? count_q + 1'b1 : count_q - 1'b1;
			end else if (cycle_clear) begin
				count_d = '0;
			end else begin
				count_d = count_q + 1'b1;
			end
		end
	end

	// Counter holds its value whenever start is 0, except on a bus write of count
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			count_q <= `TMERR_RST_COUNT;
		end else begin
			count_q <= count_d;
		end
	end

	// Timer internal output A; kept whatever the pin function
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			out_a_q <= 1'b0;
		end else if (wr_ioc) begin
			case (mode_q)
				TMERR_PWM_MODE_TWO: out_a_q <= out_a_q;
				default: out_a_q <= ioc_new.a_init;
			endcase
		end else begin
			case (mode_q)
				TMERR_PWM1: begin
					if (match_a) begin
						out_a_q <= ioc_q.a_match;
					end else if (match_b) begin
						out_a_q <= ioc_q.b_match;
					end
				end
				TMERR_PWM_MODE_TWO: out_a_q <= out_a_q;
				default: begin
					if (match_a) begin
						out_a_q <= ioc_q.a_match;
					end
				end
			endcase
		end
	end

	// Timer internal output B
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			out_b_q <= 1'b0;
		end else if (wr_ioc) begin
			case (mode_q)
				TMERR_PWM1: out_b_q <= out_b_q;
				default: out_b_q <= ioc_new.b_init;
			endcase
		end else begin
			case (mode_q)
				TMERR_PWM1: out_b_q <= out_b_q;
				TMERR_PWM_MODE_TWO: begin
					if (match_b) begin
						out_b_q <= ioc_q.b_match;
					end else if (match_a) begin
						out_b_q <= ioc_q.b_init;
					end
				end
				default: begin
					if (match_b) begin
						out_b_q <= ioc_q.b_match;
					end
				end
			endcase
		end
	end

	tmerr_pin u_pin_a (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.sel_i('{func: func_a_q, port_level: port_a_q, timer_level: out_a_q}),
		.pin_o(pin_a)
	);

	tmerr_pin u_pin_b (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.sel_i('{func: func_b_q, port_level: port_b_q, timer_level: out_b_q}),
		.pin_o(pin_b)
	);

	assign channel_output_a_o = pin_a.level;
	assign channel_output_a_oe_o = pin_a.oe;
	assign channel_output_b_o = pin_b.level;
	assign channel_output_b_oe_o = pin_b.oe;

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata = '0;
		case (haddr_i[`TMERR_HADDR_MSB:0])
			`TMERR_OFS_MODE: begin
				rdata[`TMERR_MODE_MSB:`TMERR_MODE_LSB] = mode_q;
				rdata[`TMERR_PSC_MSB:`TMERR_PSC_LSB] = psc_q;
			end
			`TMERR_OFS_IOC: rdata[`TMERR_IOC_MSB:`TMERR_IOC_LSB] = ioc_q;
			`TMERR_OFS_START: rdata[`TMERR_START_BIT] = start_q;
			`TMERR_OFS_FUNC: begin
				rdata[`TMERR_FUNC_A_MSB:`TMERR_FUNC_A_LSB] = func_a_q;
				rdata[`TMERR_FUNC_B_MSB:`TMERR_FUNC_B_LSB] = func_b_q;
			end
			`TMERR_OFS_PORT: begin
				rdata[`TMERR_PORT_A_BIT] = port_a_q;
				rdata[`TMERR_PORT_B_BIT] = port_b_q;
			end
			`TMERR_OFS_CMPA: rdata[CW-1:0] = cmpa_q;
			`TMERR_OFS_CMPB: rdata[CW-1:0] = cmpb_q;
			`TMERR_OFS_COUNT: rdata[CW-1:0] = count_q;
			`TMERR_OFS_STAT: rdata[`TMERR_STAT_MSB:`TMERR_STAT_LSB] = {start_q, out_b_q, out_a_q};
			default: rdata = '0;
		endcase
	end

	// Read data is latched at the address phase and stands in the data phase
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			hrdata_o <= '0;
			hreadyout_o <= 1'b1;
			hresp_o <= `TMERR_HRESP_OKAY;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= `TMERR_HRESP_OKAY;
			if (take && !hwrite_i) begin
				hrdata_o <= rdata;
			end
		end
	end

endmodule // tmerr_top

/* verif/tmerr_top_checker.sv */
// Port assertions for the timer channel: bus answers, pin release, halt.
// Assumes one AHB-Lite master doing word writes; bound below.
`timescale 1ns/1ps
`include "tmerr_cfg.svh"
module tmerr_top_checker #(
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// Pins
	input wire logic channel_output_a_o,
	input wire logic channel_output_a_oe_o,
	input wire logic channel_output_b_o,
	input wire logic channel_output_b_oe_o
);
	logic take_w, wr_q, rd_q, start_q, quiet_w;
	logic [7:0] adr_q;
	logic [3:0] func_q;
	logic [2:0] hist_q;
	logic [1:0] port_q, pin_w, oe_w;
	assign take_w = hsel_i && hready_i && htrans_i[`TMERR_HTRANS_NONSEQ_BIT];
	assign pin_w = {channel_output_b_o, channel_output_a_o};
	assign oe_w = {channel_output_b_oe_o, channel_output_a_oe_o};
	// Quiet means no write landed recently enough to still move a pin
	assign quiet_w = !wr_q && hist_q == 3'h0;
	always_ff @(posedge clock_i) begin
		wr_q <= !reset_i && take_w && hwrite_i;
		rd_q <= !reset_i && take_w && !hwrite_i;
		hist_q <= reset_i ? 3'h0 : {hist_q[1:0], wr_q};
		if (take_w) begin
			adr_q <= haddr_i[7:0];
		end
	end
	// Shadow of the fields the master wrote
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			func_q <= 4'h0;
			port_q <= 2'h0;
			start_q <= 1'b0;
		end else if (wr_q) begin
			if (adr_q == `TMERR_OFS_FUNC) begin
				func_q <= hwdata_i[3:0];
			end
			if (adr_q == `TMERR_OFS_PORT) begin
				port_q <= hwdata_i[1:0];
			end
			if (adr_q == `TMERR_OFS_START) begin
				start_q <= hwdata_i[0];
			end
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	property p_ready;
		hreadyout_o;
	endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
	property p_okay;
		hresp_o == `TMERR_HRESP_OKAY;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_reset;
		$past(reset_i) |-> oe_w == 2'h0 && pin_w == 2'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("pins active after reset");
	property p_hold;
		$changed(hrdata_o) && !$past(reset_i) |-> rd_q;
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_unmapped;
		rd_q && adr_q > `TMERR_OFS_STAT |-> hrdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_func_rd;
		rd_q && adr_q == `TMERR_OFS_FUNC && !hist_q[0] |-> hrdata_o == {28'h0, func_q};
	endproperty
	a_func_rd: assert property (p_func_rd) else $error("pin function readback wrong");
	property p_port_a;
		quiet_w && func_q[1:0] == `TMERR_FUNC_PORT
			|-> channel_output_a_oe_o && channel_output_a_o == port_q[0];
	endproperty
	a_port_a: assert property (p_port_a) else $error("port value not on pin A");
	property p_hiz_b;
		quiet_w && func_q[3:2] == `TMERR_FUNC_HIZ |-> !channel_output_b_oe_o;
	endproperty
	a_hiz_b: assert property (p_hiz_b) else $error("pin B driven while high-Z");
	property p_oe_cause;
		$changed(oe_w) && !$past(reset_i) |-> !quiet_w;
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("enable moved without write");
	property p_halt;
		$changed(pin_w) && !$past(reset_i) |-> start_q || !quiet_w;
	endproperty
	a_halt: assert property (p_halt) else $error("pin moved while halted");
endmodule // tmerr_top_checker

bind tmerr_top tmerr_top_checker #(.CW(CW)) u_chk (
	.clock_i(clock_i),
	.reset_i(reset_i),
	.hsel_i(hsel_i),
	.haddr_i(haddr_i),
	.htrans_i(htrans_i),
	.hwrite_i(hwrite_i),
	.hwdata_i(hwdata_i),
	.hready_i(hready_i),
	.hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o),
	.channel_output_a_o(channel_output_a_o),
	.channel_output_a_oe_o(channel_output_a_oe_o),
	.channel_output_b_o(channel_output_b_o),
	.channel_output_b_oe_o(channel_output_b_oe_o)
);

/* verif/tmerr_load.sv */
// External load on both channel pins, giving the level seen at each pad.
// Assumes no pull resistor: a released pad drifts off its last level.
`timescale 1ns/1ps
module tmerr_load (
	// Clock
	input wire logic clock_i,
	// Pins
	input wire logic [1:0] level_i,
	input wire logic [1:0] oe_i,
	// Pads
	output logic [1:0] pad_o
);
	logic [1:0] last_q = 2'h0;
	always_ff @(posedge clock_i) begin
		last_q <= pad_o;
	end
	// Undriven pads toggle so a stale level never passes
	assign pad_o = (oe_i & level_i) | (~oe_i & ~last_q);
endmodule // tmerr_load

/* verif/tmerr_top_test.sv */
// Bench for error stop and recovery of the timer channel over AHB-Lite.
// Assumes the bound checker and a load model on the pins.
`timescale 1ns/1ps
`include "tmerr_cfg.svh"
module tmerr_top_test
	import tmerr_pkg::*;
;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp;
	logic [1:0] lvl, oe, pad;
	int n_mismatch = 0;
	int total_checks = 0;
	tmerr_mode_t tl[5] = '{TMERR_NORMAL, TMERR_PWM1, TMERR_PWM_MODE_TWO, TMERR_PWM_MODE_TWO, TMERR_PHASE};
	tmerr_top #(.CW(16)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.phase_a_i(pa), .phase_b_i(pb), .channel_output_a_o(lvl[0]),
		.channel_output_a_oe_o(oe[0]), .channel_output_b_o(lvl[1]),
		.channel_output_b_oe_o(oe[1])
	);
	tmerr_load load (.clock_i(clock_i), .level_i(lvl), .oe_i(oe), .pad_o(pad));
	task automatic wrap_up();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t word %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t bit %b not %b", $time, got, exp);
		end
	endtask
	// Waits as long as the slave stalls; only the watchdog ends a hang
	task automatic wait_rdy();
		do
			@(posedge clock_i);
		while (hready !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock_i);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	// Write, then let the pin register follow
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
	endtask
	// Run, then stop as after an error; s returns the internal outputs
	task automatic run(output logic [31:0] s, output logic low);
		logic [31:0] c0, c1;
		low = 1'b0;
		wr(`TMERR_OFS_START, 32'h1);
		bus(1'b0, `TMERR_OFS_COUNT, 32'h0, c0);
		for (int i = 0; i < 50; i++) begin
			@(posedge clock_i);
			pa <= ~pb;
			pb <= pa;
			@(negedge clock_i);
			low = low | (pad[1] === 1'b0);
		end
		bus(1'b0, `TMERR_OFS_COUNT, 32'h0, c1);
		chk_bit(c1 !== c0, 1'b1);
		wr(`TMERR_OFS_PORT, 32'h3);
		wr(`TMERR_OFS_FUNC, 32'h5);
		chk_word({30'h0, pad}, 32'h3);
		wr(`TMERR_OFS_START, 32'h0);
		bus(1'b0, `TMERR_OFS_COUNT, 32'h0, c0);
		repeat (5) @(posedge clock_i);
		bus(1'b0, `TMERR_OFS_COUNT, 32'h0, c1);
		chk_word(c1, c0);
		bus(1'b0, `TMERR_OFS_STAT, 32'h0, s);
	endtask
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	initial begin
		#1000000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		logic [31:0] s, q;
		logic low;
		logic [1:0] exp;
		tmerr_mode_t cur;
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		@(negedge clock_i);
		chk_word({30'h0, oe}, 32'h0);
		bus(1'b0, `TMERR_OFS_STAT, 32'h0, q);
		chk_word(q, 32'h0);
		wr(8'h44, 32'h5);
		bus(1'b0, 8'h44, 32'h0, q);
		chk_word(q, 32'h0);
		wr(`TMERR_OFS_CMPA, 32'hC);
		wr(`TMERR_OFS_CMPB, 32'h5);
		wr(`TMERR_OFS_COUNT, 32'h7);
		bus(1'b0, `TMERR_OFS_COUNT, 32'h0, q);
		chk_word(q, 32'h7);
		wr(`TMERR_OFS_MODE, {30'h0, TMERR_PWM_MODE_TWO});
		wr(`TMERR_OFS_IOC, 32'h5);
		bus(1'b0, `TMERR_OFS_STAT, 32'h0, q);
		chk_word(q, 32'h2);
		wr(`TMERR_OFS_FUNC, 32'hA);
		bus(1'b0, `TMERR_OFS_FUNC, 32'h0, q);
		chk_word(q, 32'hA);
		chk_bit(pad[1], 1'b1);
		run(s, low);
		chk_bit(low, 1'b1);
		cur = TMERR_PWM_MODE_TWO;
		for (int m = 0; m < 5; m++) begin
			if (tl[m] != cur)
				wr(`TMERR_OFS_MODE, {28'h0, (tl[m] == TMERR_NORMAL) ? `TMERR_PSC_DIV4 : `TMERR_PSC_DIV1, tl[m]});
			cur = tl[m];
			wr(`TMERR_OFS_IOC, {28'h0, 1'b0, ~s[1], 1'b0, ~s[0]});
			exp = ~s[1:0];
			if (cur == TMERR_PWM1)
				exp[1] = s[1];
			if (cur == TMERR_PWM_MODE_TWO)
				exp[0] = s[0];
			bus(1'b0, `TMERR_OFS_STAT, 32'h0, q);
			chk_word(q, {30'h0, exp});
			wr(`TMERR_OFS_FUNC, 32'hA);
			chk_word({30'h0, pad}, {30'h0, exp});
			run(s, low);
		end
		wrap_up();
	end
endmodule // tmerr_top_test
